// ### shared/logger_params.svh
// constants of the triggered parameter logger: offsets, fields, codes, timing
// assumes the includer works on the 100 MHz system clock
`ifndef LOGGER_PARAMS_SVH
`define LOGGER_PARAMS_SVH
`define LOG_DEPTH 17'h0f900
`define LOG_NPARAM 7'h3d
`define LOG_WIDE_SET 61'h0c00000000080002
`define LOG_BUF_WORDS 16'h0041
`define LOG_PCT_FULL 32'h00000064
`define LOG_CLK_NS 10
`define LOG_MS_NS 1000000
`define A_REC_SEL 16'ha473
`define A_RUN 16'ha475
`define A_POST_PCT 16'ha476
`define A_PERIOD 16'ha477
`define A_EN_LO 16'ha478
`define A_EN_HI 16'ha47a
`define A_MODE 16'ha47c
`define A_C1_TYPE 16'ha47d
`define A_C1_SRC 16'ha47e
`define A_C1_MASK 16'ha47f
`define A_C1_THR 16'ha481
`define A_C2_TYPE 16'ha483
`define A_C2_SRC 16'ha484
`define A_C2_MASK 16'ha485
`define A_C2_THR 16'ha487
`define A_STATUS 16'ha489
`define A_COUNT 16'ha48a
`define A_WPS 16'ha48b
`define A_BUF_BASE 16'ha494
`define RUN_BIT 0
`define MODE_CONT 2'h0
`define MODE_SINGLE 2'h1
`define MODE_OR 2'h2
`define MODE_AND 2'h3
`define CMP_LT 2'h0
`define CMP_GT 2'h1
`define CMP_EQ 2'h2
`define ST_CODE_IDLE 2'h0
`define ST_CODE_WAIT 2'h1
`define ST_CODE_CAPT 2'h2
`define ST_CODE_DONE 2'h3
`define RST_MASK 32'hffffffff
`define RST_PERIOD 16'h0001
`endif

// ### shared/logger_pkg.sv
// types of the triggered parameter logger
// assumes nothing beyond the constants header
package logger_pkg;
  typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT, CAP_POST, CAP_DONE} cap_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// ### logic/triggered_parameter_logger.sv
// triggered parameter logger: sampling, triggers, circular capture memory, readout
// assumes param_values and req come from logic on clk; strobes are one cycle long
//
// Overview of operation
// - writing a record index presents that record's words in the read buffer window
// - enabled parameters are sampled each period and written continuously; trigger freezes or fills
// - two 32-bit enable registers, low holds bits 0-31, high bits 32-63
// - bit 0 converter state, 1 fault word, 59 warnings, 60 state; 61-63 unused
// - capture memory holds exactly 63744 words; span is capacity over words per sample
// - 16-bit parameters take one word, 32-bit parameters take two
// - sample interval comes from the sample period register, in milliseconds
// - post-trigger percent: 0 all before, 50 split, 100 all after trigger
// - continuous mode samples while run is 1, overwriting the oldest entries
// - trigger mode 0 continuous, 1 single, 2 dual or, 3 dual and
// - single mode triggers when run is 1 and comparator 1 holds
// - dual or mode triggers when run is 1 and either comparator holds
// - dual and mode triggers when run is 1 and both comparators hold
// - source select holds the parameter number each comparator watches
// - each comparator ands its parameter with its mask before comparing
// - compare type 0 less, 1 greater, 2 equal, 3 not equal to threshold
// - status reads 1 or 2 while waiting or capturing, 3 when finished
// - record index is zero based, 0 is the oldest stored record
//
// The implementer's own choice: the plain strobed port.
`include "logger_params.svh"
`timescale 1ns/100ps
`default_nettype none

module triggered_parameter_logger
  import logger_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `LOG_MS_NS / `LOG_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire reg_req_s req,
  input wire logic [60:0][31:0] param_values,
  output logic [31:0] rdata,
  output logic [1:0] cap_status,
  output logic capturing
);

  localparam int MSW = $clog2(CYC_PER_MS + 1);
  localparam logic [60:0] WIDE = `LOG_WIDE_SET;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [6:0] words_per(input logic [60:0] en);
    logic [6:0] n;
    n = '0;
    for (int i = 0; i < 61; i++) begin
      n = n + 7'(en[i]) + 7'(en[i] & WIDE[i]);
    end
    return n;
  endfunction

  function automatic logic [31:0] pick(input logic [15:0] s, input logic [60:0][31:0] pv);
    logic [31:0] v;
    v = '0;
    if (s < 16'(`LOG_NPARAM)) begin
      v = pv[s[5:0]];
    end
    return v;
  endfunction

  function automatic logic hit(input logic [31:0] v, input logic [31:0] m, input logic [31:0] t,
                               input logic [1:0] ty);
    logic [31:0] x;
    logic r;
    x = v & m;
    case (ty)
      `CMP_LT: r = x < t;
      `CMP_GT: r = x > t;
      `CMP_EQ: r = x == t;
      default: r = x != t;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [15:0] sel_q, pct_q, per_q, mode_q, c1t_q, c1s_q, c2t_q, c2s_q;
  logic [31:0] enl_q, enh_q, c1m_q, c1v_q, c2m_q, c2v_q;
  logic run_q;
  wire run_rise = req.wr && req.addr == `A_RUN && req.wdata[`RUN_BIT] && !run_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= '0; run_q <= 1'b0; pct_q <= '0; per_q <= `RST_PERIOD;
      enl_q <= '0; enh_q <= '0; mode_q <= '0;
      c1t_q <= '0; c1s_q <= '0; c1m_q <= `RST_MASK; c1v_q <= '0;
      c2t_q <= '0; c2s_q <= '0; c2m_q <= `RST_MASK; c2v_q <= '0;
    end else if (req.wr) begin
      case (req.addr)
        `A_REC_SEL: sel_q <= req.wdata[15:0];
        `A_RUN: run_q <= req.wdata[`RUN_BIT];
        `A_POST_PCT: pct_q <= req.wdata[15:0];
        `A_PERIOD: per_q <= req.wdata[15:0];
        `A_EN_LO: enl_q <= req.wdata;
        `A_EN_HI: enh_q <= req.wdata;
        `A_MODE: mode_q <= req.wdata[15:0];
        `A_C1_TYPE: c1t_q <= req.wdata[15:0];
        `A_C1_SRC: c1s_q <= req.wdata[15:0];
        `A_C1_MASK: c1m_q <= req.wdata;
        `A_C1_THR: c1v_q <= req.wdata;
        `A_C2_TYPE: c2t_q <= req.wdata[15:0];
        `A_C2_SRC: c2s_q <= req.wdata[15:0];
        `A_C2_MASK: c2m_q <= req.wdata;
        `A_C2_THR: c2v_q <= req.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample timing: millisecond tick, then period in ms

  logic [MSW-1:0] ms_cnt_q;
  logic [15:0] per_cnt_q;
  wire ms_tick = ms_cnt_q == MSW'(CYC_PER_MS - 1);
  wire [15:0] per_eff = (per_q == '0) ? `RST_PERIOD : per_q;
  wire per_end = per_cnt_q + `RST_PERIOD >= per_eff;
  wire sample_tick = ms_tick && per_end;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_q <= '0;
      per_cnt_q <= '0;
    end else begin
      ms_cnt_q <= (ms_tick || run_rise) ? '0 : ms_cnt_q + MSW'(1);
      if (run_rise || sample_tick) begin
        per_cnt_q <= '0;
      end else if (ms_tick) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // triggers

  wire [1:0] mode = mode_q[1:0];
  wire h1 = hit(pick(c1s_q, param_values), c1m_q, c1v_q, c1t_q[1:0]);
  wire h2 = hit(pick(c2s_q, param_values), c2m_q, c2v_q, c2t_q[1:0]);
  wire trig = run_q && ((mode == `MODE_SINGLE && h1) ||
                        (mode == `MODE_OR && (h1 || h2)) ||
                        (mode == `MODE_AND && h1 && h2));

  ////////////////////////////////////////////////////////////////////////////
  // capture control and walk over enabled parameters

  cap_state_e state_q;
  logic [60:0] en_q;
  logic [6:0] wps_q;
  logic [16:0] wptr_q, ring_end_q, post_cnt_q;
  logic [15:0] cnt_q;
  logic wrapped_q, walk_q, half_q;
  logic [5:0] idx_q;

  // enables latched at start so every record shares one layout
  wire [60:0] en_all = {enh_q[28:0], enl_q};
  wire [6:0] wps_new = words_per(en_all);
  wire active = state_q == CAP_WAIT || state_q == CAP_POST;
  wire start_smp = sample_tick && active && !walk_q && run_q && wps_q != '0;
  wire wrap_now = wptr_q + 17'(wps_q) > `LOG_DEPTH;
  wire cur_en = en_q[idx_q];
  wire cur_wide = WIDE[idx_q];
  wire wr_now = walk_q && cur_en;
  wire adv = !cur_en || !cur_wide || half_q;
  wire walk_end = walk_q && adv && idx_q == 6'(`LOG_NPARAM - 7'h01);
  wire [15:0] wword = (cur_wide && !half_q) ? param_values[idx_q][31:16] :
                      param_values[idx_q][15:0];
  wire [15:0] pct_eff = (pct_q > 16'(`LOG_PCT_FULL)) ? 16'(`LOG_PCT_FULL) : pct_q;
  wire [31:0] post_prod = 32'(pct_eff) * 32'(`LOG_DEPTH);
  wire [16:0] post_words = 17'(post_prod / `LOG_PCT_FULL);
  wire [16:0] post_nx = post_cnt_q + 17'(wps_q);
  wire post_full = post_nx + 17'(wps_q) > post_words;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CAP_IDLE;
      en_q <= '0; wps_q <= '0; wptr_q <= '0; ring_end_q <= `LOG_DEPTH;
      cnt_q <= '0; wrapped_q <= 1'b0; post_cnt_q <= '0;
    end else if (run_rise) begin
      state_q <= CAP_WAIT;
      en_q <= en_all; wps_q <= wps_new; wptr_q <= '0; ring_end_q <= `LOG_DEPTH;
      cnt_q <= '0; wrapped_q <= 1'b0; post_cnt_q <= '0;
    end else begin
      if (start_smp) begin
        if (wrap_now) begin
          // ring ends at the last whole record, so no record straddles the end
          ring_end_q <= wptr_q;
          wptr_q <= '0;
          wrapped_q <= 1'b1;
        end
        if (!wrap_now && !wrapped_q) begin
          cnt_q <= cnt_q + 16'h0001;
        end
        if (state_q == CAP_WAIT && trig) begin
          state_q <= CAP_POST;
        end
      end else if (wr_now) begin
        wptr_q <= wptr_q + 17'h00001;
      end
      if (walk_end && state_q == CAP_POST) begin
        post_cnt_q <= post_nx;
        if (post_full) begin
          state_q <= CAP_DONE;
        end
      end else if (!run_q && active && !walk_q && !start_smp) begin
        state_q <= CAP_DONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      walk_q <= 1'b0; idx_q <= '0; half_q <= 1'b0;
    end else if (run_rise) begin
      // a restart drops the walk in flight, so no stray words land at the new pointer
      walk_q <= 1'b0; idx_q <= '0; half_q <= 1'b0;
    end else if (start_smp) begin
      walk_q <= 1'b1; idx_q <= '0; half_q <= 1'b0;
    end else if (walk_q) begin
      walk_q <= !walk_end;
      idx_q <= walk_end ? 6'h00 : (adv ? idx_q + 6'h01 : idx_q);
      half_q <= !adv;
    end
  end

  // capture memory: one write port, read combinationally into the read data flop
  logic [15:0] mem [0:`LOG_DEPTH-1];
  always_ff @(posedge clk) begin
    if (wr_now) begin
      mem[wptr_q[15:0]] <= wword;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout: selected record through the buffer window

  wire [16:0] oldest = (wrapped_q && wptr_q < ring_end_q) ? wptr_q : '0;
  wire [22:0] rec_off = 23'(sel_q) * 23'(wps_q);
  wire [23:0] rec_sum = 24'(oldest) + 24'(rec_off);
  wire [23:0] rec_base = (rec_sum >= 24'(ring_end_q)) ? rec_sum - 24'(ring_end_q) : rec_sum;
  wire [15:0] buf_k = req.addr - `A_BUF_BASE;
  wire buf_hit = req.addr >= `A_BUF_BASE && buf_k < `LOG_BUF_WORDS;
  wire buf_ok = sel_q < cnt_q && buf_k < 16'(wps_q);
  wire [16:0] mem_a = rec_base[16:0] + 17'(buf_k);
  wire [15:0] buf_word = buf_ok ? mem[mem_a[15:0]] : '0;

  wire [1:0] status_code = (state_q == CAP_IDLE) ? `ST_CODE_IDLE :
                           (state_q == CAP_DONE) ? `ST_CODE_DONE :
                           (state_q == CAP_POST || mode == `MODE_CONT) ? `ST_CODE_CAPT :
                           `ST_CODE_WAIT;

  wire [31:0] rd_val =
    buf_hit ? 32'(buf_word) :
    req.addr == `A_REC_SEL ? 32'(sel_q) :
    req.addr == `A_RUN ? 32'(run_q) :
    req.addr == `A_POST_PCT ? 32'(pct_q) :
    req.addr == `A_PERIOD ? 32'(per_q) :
    req.addr == `A_EN_LO ? enl_q :
    req.addr == `A_EN_HI ? enh_q :
    req.addr == `A_MODE ? 32'(mode_q) :
    req.addr == `A_C1_TYPE ? 32'(c1t_q) :
    req.addr == `A_C1_SRC ? 32'(c1s_q) :
    req.addr == `A_C1_MASK ? c1m_q :
    req.addr == `A_C1_THR ? c1v_q :
    req.addr == `A_C2_TYPE ? 32'(c2t_q) :
    req.addr == `A_C2_SRC ? 32'(c2s_q) :
    req.addr == `A_C2_MASK ? c2m_q :
    req.addr == `A_C2_THR ? c2v_q :
    req.addr == `A_STATUS ? 32'(status_code) :
    req.addr == `A_COUNT ? 32'(cnt_q) :
    req.addr == `A_WPS ? 32'(wps_q) : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0; cap_status <= `ST_CODE_IDLE; capturing <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_val : '0;
      cap_status <= status_code;
      capturing <= active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  status_read_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == `A_STATUS |=> rdata == 32'($past(status_code)))
    else $error("status read returned wrong value");
  cont_no_trig_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      state_q == CAP_WAIT && mode == `MODE_CONT && !run_rise |=> state_q != CAP_POST)
    else $error("continuous mode left waiting by trigger");
  single_trig_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $rose(state_q == CAP_POST) && mode == `MODE_SINGLE |-> $past(h1) && $past(run_q))
    else $error("single trigger without comparator 1");
  or_trig_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $rose(state_q == CAP_POST) && mode == `MODE_OR |-> $past(h1 || h2))
    else $error("or trigger without any comparator");
  and_trig_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $rose(state_q == CAP_POST) && mode == `MODE_AND |-> $past(h1 && h2))
    else $error("and trigger without both comparators");
  walk_start_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      start_smp |=> walk_q && idx_q == 6'h00 && !half_q)
    else $error("walk did not start at bit 0");
  wide_order_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      wr_now && cur_wide && !half_q |=> wr_now && half_q && idx_q == $past(idx_q))
    else $error("wide parameter not stored as two words");
  ptr_bound_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      wr_now |-> wptr_q < `LOG_DEPTH)
    else $error("write beyond capture memory");
  done_freeze_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      state_q == CAP_DONE && !run_rise |=> !walk_q && state_q == CAP_DONE)
    else $error("capture memory written after done");
  start_latch_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      run_rise |=> state_q == CAP_WAIT && en_q == $past(en_all) && wptr_q == '0)
    else $error("start did not latch enables");
  wps_bound_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      wps_q <= 7'(`LOG_BUF_WORDS))
    else $error("words per sample beyond window");
  wptr_step_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      wr_now && !run_rise |=> wptr_q == $past(wptr_q) + 17'h00001)
    else $error("write pointer did not step per word");
  ring_ptr_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      wptr_q <= ring_end_q)
    else $error("write pointer past ring end");
  run_stop_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      !run_q |-> !start_smp)
    else $error("sample started while stopped");
  trig_tick_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $rose(state_q == CAP_POST) |-> $past(start_smp))
    else $error("trigger taken off a sample tick");
  // a zero mask leaves only the threshold to decide
  mask_apply_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      c1m_q == '0 && c1t_q[1:0] == `CMP_EQ && c1v_q == '0 |-> h1)
    else $error("mask not applied before compare");
  active_status_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      active |=> cap_status == `ST_CODE_WAIT || cap_status == `ST_CODE_CAPT)
    else $error("busy status not 1 or 2");
  done_idle_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      state_q == CAP_DONE |=> !capturing)
    else $error("capturing flag high after done");
  read_idle_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      !req.rd |=> rdata == '0)
    else $error("read data without read strobe");
  rec_window_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      req.rd && buf_hit && !buf_ok |=> rdata == '0)
    else $error("absent record word not zero");
  sel_read_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      req.rd && req.addr == `A_REC_SEL |=> rdata == 32'($past(sel_q)))
    else $error("record select read wrong");

endmodule // triggered_parameter_logger

`default_nettype wire

// ### bench/triggered_parameter_logger_test.sv
// self-checking bench for the triggered parameter logger: registers, capture, triggers, readout
// assumes logger_pkg and logger_params.svh are compiled first; one 100 MHz clock
`include "logger_params.svh"
`timescale 1ns/100ps
`default_nettype none

module triggered_parameter_logger_test
  import logger_pkg::*;
;
  logic clk;
  logic rst_b;
  reg_req_s req;
  logic [60:0][31:0] pv;
  logic [31:0] rdata;
  logic [1:0] cap_status;
  logic capturing;
  int n_errors;
  int n_checks;
  logic [31:0] v;

  // short millisecond: a tick every 20 cycles; ticks inside a walk are skipped
  triggered_parameter_logger #(.CYC_PER_MS(20)) dut (
    .clk(clk),
    .rst_b(rst_b),
    .req(req),
    .param_values(pv),
    .rdata(rdata),
    .cap_status(cap_status),
    .capturing(capturing)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // read data is valid only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic wait_st(input logic [1:0] code, input int lim);
    for (int i = 0; i < lim && cap_status !== code; i++) @(negedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`A_STATUS, v);
    check("idle status", v, 32'h00000000);
    @(negedge clk);
    check("read data one cycle", rdata, 32'h00000000);
    rd(`A_PERIOD, v);
    check("period reset", v, 32'h00000001);
    rd(`A_C1_MASK, v);
    check("mask1 reset", v, 32'hffffffff);
    rd(`A_C2_MASK, v);
    check("mask2 reset", v, 32'hffffffff);
    wr(`A_EN_HI, 32'hf8000000);
    rd(`A_EN_HI, v);
    check("enable high", v, 32'hf8000000);
    rd(16'ha490, v);
    check("unmapped", v, 32'h00000000);
  endtask

  // bit 0 narrow, 59 wide, 60 narrow, 61-63 reserved: four words per sample
  task automatic t_cont;
    @(posedge clk);
    pv[0] <= 32'h1234a5a5;
    pv[59] <= 32'hcafe0123;
    pv[60] <= 32'h00005a5a;
    wr(`A_EN_LO, 32'h00000001);
    wr(`A_MODE, {30'h0, `MODE_CONT});
    wr(`A_RUN, 32'h00000000);
    wr(`A_RUN, 32'h00000001);
    repeat (150) @(negedge clk);
    check("running status", {30'h0, cap_status}, 32'h00000002);
    check("capturing", {31'h0, capturing}, 32'h00000001);
    rd(`A_WPS, v);
    check("words per sample", v, 32'h00000004);
    wr(`A_RUN, 32'h00000000);
    wait_st(`ST_CODE_DONE, 200);
    check("done status", {30'h0, cap_status}, 32'h00000003);
    for (int r = 0; r < 2; r++) begin
      wr(`A_REC_SEL, r);
      rd(`A_BUF_BASE, v);
      check("word0", v, 32'h0000a5a5);
      rd(`A_BUF_BASE + 16'h0001, v);
      check("word1", v, 32'h0000cafe);
      rd(`A_BUF_BASE + 16'h0002, v);
      check("word2", v, 32'h00000123);
      rd(`A_BUF_BASE + 16'h0003, v);
      check("word3", v, 32'h00005a5a);
      rd(`A_BUF_BASE + 16'h0004, v);
      check("word4", v, 32'h00000000);
    end
    wr(`A_REC_SEL, 32'h000003e8);
    rd(`A_BUF_BASE, v);
    check("absent record", v, 32'h00000000);
    rd(`A_REC_SEL, v);
    check("record select", v, 32'h000003e8);
    wr(`A_EN_HI, 32'h00000000);
  endtask

  // post share 0: done right after the trigger sample
  task automatic t_trig(input logic [1:0] m, input logic [1:0] t1, input logic [31:0] v1,
                        input logic [1:0] t2, input logic [31:0] v2, input logic hit);
    wr(`A_MODE, {30'h0, m});
    wr(`A_C1_TYPE, {30'h0, t1});
    wr(`A_C1_THR, v1);
    wr(`A_C2_TYPE, {30'h0, t2});
    wr(`A_C2_THR, v2);
    wr(`A_RUN, 32'h00000000);
    wr(`A_RUN, 32'h00000001);
    // status lags state by one cycle, so the done code of the last run must clear first
    repeat (2) @(negedge clk);
    check("armed", {30'h0, cap_status}, 32'h00000001);
    if (hit) begin
      wait_st(`ST_CODE_DONE, 300);
      check("triggered", {30'h0, cap_status}, 32'h00000003);
    end else begin
      repeat (200) @(negedge clk);
      check("waiting", {30'h0, cap_status}, 32'h00000001);
    end
    wr(`A_RUN, 32'h00000000);
    wait_st(`ST_CODE_DONE, 200);
  endtask

  task automatic t_trig_all;
    @(posedge clk);
    pv[3] <= 32'h00000064;
    pv[53] <= 32'h00000032;
    pv[1] <= 32'h00000401;
    wr(`A_POST_PCT, 32'h00000000);
    wr(`A_C1_SRC, 32'h00000003);
    wr(`A_C2_SRC, 32'h00000035);
    t_trig(`MODE_SINGLE, `CMP_LT, 32'hc8, `CMP_EQ, 32'h0, 1'b1);
    t_trig(`MODE_SINGLE, `CMP_GT, 32'hc8, `CMP_EQ, 32'h32, 1'b0);
    t_trig(`MODE_SINGLE, `CMP_EQ, 32'h64, `CMP_EQ, 32'h0, 1'b1);
    t_trig(`MODE_SINGLE, 2'h3, 32'h64, `CMP_EQ, 32'h0, 1'b0);
    t_trig(`MODE_OR, `CMP_GT, 32'hc8, `CMP_EQ, 32'h32, 1'b1);
    t_trig(`MODE_OR, `CMP_GT, 32'hc8, `CMP_LT, 32'h10, 1'b0);
    t_trig(`MODE_AND, `CMP_LT, 32'hc8, `CMP_LT, 32'h10, 1'b0);
    t_trig(`MODE_AND, `CMP_LT, 32'hc8, `CMP_EQ, 32'h32, 1'b1);
    wr(`A_C1_SRC, 32'h00000001);
    wr(`A_C1_MASK, 32'h00000400);
    t_trig(`MODE_SINGLE, `CMP_EQ, 32'h400, `CMP_EQ, 32'h0, 1'b1);
    t_trig(`MODE_SINGLE, `CMP_EQ, 32'h401, `CMP_EQ, 32'h0, 1'b0);
    wr(`A_C1_MASK, 32'h00000000);
    t_trig(`MODE_SINGLE, `CMP_EQ, 32'h0, `CMP_EQ, 32'h0, 1'b1);
  endtask

  // all 61 enables give 65 words; 1% of the memory is 637 words, nine whole samples
  task automatic t_post;
    wr(`A_EN_LO, 32'hffffffff);
    wr(`A_EN_HI, 32'h1fffffff);
    wr(`A_POST_PCT, 32'h00000001);
    wr(`A_C1_MASK, 32'hffffffff);
    wr(`A_C1_THR, 32'h00000401);
    wr(`A_C1_TYPE, {30'h0, `CMP_EQ});
    wr(`A_MODE, {30'h0, `MODE_SINGLE});
    wr(`A_RUN, 32'h00000000);
    wr(`A_RUN, 32'h00000001);
    repeat (2) @(negedge clk);
    check("post armed", {30'h0, cap_status}, 32'h00000001);
    wait_st(`ST_CODE_DONE, 1000);
    check("post done", {30'h0, cap_status}, 32'h00000003);
    check("capturing after done", {31'h0, capturing}, 32'h00000000);
    rd(`A_WPS, v);
    check("all words per sample", v, 32'h00000041);
    rd(`A_COUNT, v);
    check("post samples", v, 32'h00000009);
    wr(`A_REC_SEL, 32'h00000008);
    rd(`A_BUF_BASE + 16'h0002, v);
    check("wide low word", v, 32'h00000401);
    rd(`A_BUF_BASE + 16'h0040, v);
    check("last word", v, 32'h00005a5a);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_b = 1'b0;
    req = '0;
    pv = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_cont;
    t_trig_all;
    t_post;
    stop_test;
  end

  // whole run needs about 3000 cycles; a hang ends well past that
  initial begin
    #500000;
    n_errors++;
    stop_test;
  end
endmodule // triggered_parameter_logger_test

`default_nettype wire
